/* design/wdt_defines.svh */
// Constants for the two-channel watchdog / interval timer
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define CS_OVF       7
`define CS_MODE      6
`define CS_EN        5
`define CS_PSS       4
`define CS_RSEL      3
`define CS_DIV_HI    2
`define CS_DIV_LO    0
`define CS_RESET     8'h00
`define CNT_MAX      8'hff
`define CNT_ZERO     8'h00
`define CNT_ONE      8'h01

`define KEY_COUNT    8'h5a
`define KEY_CTRL     8'ha5
`define KEY_HI       15
`define KEY_LO       8
`define SEL_WORD     4'h3

`define ADR_CS0      5'h00
`define ADR_CNT0     5'h04
`define ADR_CS1      5'h08
`define ADR_CNT1     5'h0c
`define ADR_IRQ_STAT 5'h10
`define ADR_IRQ_CLR  5'h14
`define ADR_IRQ_EN   5'h18

`define IRQ_OVF0     0
`define IRQ_OVF1     1
`define IRQ_NMI      2
`define IRQ_IRST     3
`define IRQ_RESET    4'h0

`define IRST_CLOCKS  10'h206
`define RESET_OUT_N_STATES  10'h084
`define SEQ_ONE      10'h001
`define SEQ_ZERO     10'h000

`define MAIN_PRE_W   17
`define SUB_PRE_W    8
`define DIV_L0       5'h01
`define DIV_L1       5'h06
`define DIV_L2       5'h07
`define DIV_L3       5'h09
`define DIV_L4       5'h0b
`define DIV_L5       5'h0d
`define DIV_L6       5'h0f
`define DIV_L7       5'h11

`endif

/* design/wdt_pkg.sv */
// Types shared by the watchdog timer modules
package wdt_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [2:0] div_code_t;
  // Gray coded along idle -> both -> tail; tail -> idle flips both bits
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_BOTH = 2'b01,
    RS_TAIL = 2'b11
  } rst_seq_t;
endpackage

/* design/wdt_channel.sv */
// One watchdog channel: counter, control/status byte and overflow flag
`timescale 1ns/100ps
`include "wdt_defines.svh"
module wdt_channel #(
  parameter bit HAS_PSS = 1'b0
) (
  // Clock and reset
  input  wire logic      clock_i,
  input  wire logic      rst_n_i,
  // Register access strobes
  input  wire logic      cs_wr_i,
  input  wire logic      cnt_wr_i,
  input  wire logic      cs_rd_i,
  input  wdt_pkg::reg8_t wdata_i,
  // Timing
  input  wire logic      tick_i,
  input  wire logic      irst_clr_i,
  // State
  output wdt_pkg::reg8_t cs_o,
  output wdt_pkg::reg8_t count_o,
  output logic           ovf_set_o
);
  import wdt_pkg::*;

  reg8_t cs_q;
  reg8_t cs_d;
  reg8_t cnt_q;
  reg8_t cnt_d;
  logic  armed_q;
  logic  armed_d;
  logic  ovf_clr;
  logic  en;

  assign en = cs_q[`CS_EN];

  always_comb begin
    ovf_set_o = tick_i && en && (cnt_q == `CNT_MAX) && !cnt_wr_i;
    ovf_clr   = 1'b0;
    if (irst_clr_i) begin
      ovf_clr = 1'b1;
    end
    if (cs_wr_i && !wdata_i[`CS_EN]) begin
      ovf_clr = 1'b1;
    end
    if (cs_wr_i && !wdata_i[`CS_OVF] && armed_q) begin
      ovf_clr = 1'b1;
    end
    cs_d = cs_q;
    if (cs_wr_i) begin
      cs_d = wdata_i;
      if (!HAS_PSS) begin
        cs_d[`CS_PSS] = 1'b0;
      end
    end
    cs_d[`CS_OVF] = ovf_set_o || (cs_q[`CS_OVF] && !ovf_clr);
    armed_d = cs_d[`CS_OVF] && ((armed_q && !cs_wr_i) || (cs_rd_i && cs_q[`CS_OVF]));
    if (!en || (cs_wr_i && !wdata_i[`CS_EN])) begin
      cnt_d = `CNT_ZERO;
    end else if (cnt_wr_i) begin
      cnt_d = wdata_i;
    end else if (tick_i) begin
      cnt_d = cnt_q + `CNT_ONE;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cs_q    <= `CS_RESET;
      cnt_q   <= `CNT_ZERO;
      armed_q <= 1'b0;
    end else begin
      cs_q    <= cs_d;
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
    end
  end

  assign cs_o    = cs_q;
  assign count_o = cnt_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_wrap_sets;
    tick_i && en && cnt_q == `CNT_MAX && !cnt_wr_i && !(cs_wr_i && !wdata_i[`CS_EN])
      |=> cs_q[`CS_OVF] && cnt_q == `CNT_ZERO;
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("wrap did not set flag");

  property p_one_ignored;
    cs_wr_i && wdata_i[`CS_OVF] && !cs_q[`CS_OVF] && !ovf_set_o |=> !cs_q[`CS_OVF];
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("write of one set flag");

  property p_unarmed_keeps;
    cs_wr_i && !armed_q && wdata_i[`CS_EN] && !irst_clr_i && cs_q[`CS_OVF] |=> cs_q[`CS_OVF];
  endproperty
  a_unarmed_keeps: assert property (p_unarmed_keeps) else $error("flag cleared without read");

  property p_arms;
    cs_rd_i && cs_q[`CS_OVF] && !irst_clr_i |=> armed_q;
  endproperty
  a_arms: assert property (p_arms) else $error("flagged read did not arm clear");

  property p_armed_clears;
    armed_q && cs_wr_i && !wdata_i[`CS_OVF] && !ovf_set_o |=> !cs_q[`CS_OVF];
  endproperty
  a_armed_clears: assert property (p_armed_clears) else $error("read then zero kept flag");

  property p_en_clear;
    cs_wr_i && !wdata_i[`CS_EN] && !ovf_set_o |=> !cs_q[`CS_OVF] && cnt_q == `CNT_ZERO;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable clear missed");

  property p_irst_clear;
    irst_clr_i && !ovf_set_o |=> !cs_q[`CS_OVF];
  endproperty
  a_irst_clear: assert property (p_irst_clear) else $error("internal reset kept flag");

  property p_hold;
    en && !tick_i && !cnt_wr_i && !cs_wr_i |=> cnt_q == $past(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tap");
endmodule

/* design/watchdog_ctrl_status_clocksel.sv */
// Two-channel watchdog / interval timer with Wishbone register access
`timescale 1ns/100ps
`include "wdt_defines.svh"
module watchdog_ctrl_status_clocksel (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sub-clock pin
  input  wire logic        sub_clk_i,
  // Overflow actions
  output logic             chip_reset_o,
  output logic             reset_out_n_o,
  output logic             nmi_o,
  output logic      [1:0]  interval_overflow_irq_o,
  output logic             irq_o
);
  import wdt_pkg::*;

  // Tap mask for the main-clock prescaler, shared by both channels
  function automatic logic [`MAIN_PRE_W-1:0] main_mask(input div_code_t code);
    logic [4:0] k;
    case (code)
      3'h0:    k = `DIV_L0;
      3'h1:    k = `DIV_L1;
      3'h2:    k = `DIV_L2;
      3'h3:    k = `DIV_L3;
      3'h4:    k = `DIV_L4;
      3'h5:    k = `DIV_L5;
      3'h6:    k = `DIV_L6;
      default: k = `DIV_L7;
    endcase
    main_mask = ~({`MAIN_PRE_W{1'b1}} << k);
  endfunction

  function automatic logic tap_hit(input logic [`MAIN_PRE_W-1:0] cnt, input logic [`MAIN_PRE_W-1:0] mask);
    tap_hit = (cnt & mask) == mask;
  endfunction

  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic        req;
  logic        commit;
  logic        wr;
  logic        word_ok;
  logic [7:0]  key;
  reg8_t       wbyte;
  reg8_t       cs0;
  reg8_t       cs1;
  reg8_t       cnt0;
  reg8_t       cnt1;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [3:0]  ien_q;
  logic [3:0]  ien_d;

  assign req     = wb_cyc_i && wb_stb_i;
  // Writes and read side effects land on the edge where the master sees ack
  assign commit  = req && ack_q;
  assign wr      = commit && wb_we_i;
  assign word_ok = (wb_sel_i & `SEL_WORD) == `SEL_WORD;
  assign key     = wb_dat_i[`KEY_HI:`KEY_LO];
  assign wbyte   = wb_dat_i[7:0];

  always_comb begin
    ack_d = req && !ack_q;
    dat_d = dat_q;
    if (req && !ack_q) begin
      case (wb_adr_i)
        `ADR_CS0:      dat_d = {24'h000000, cs0};
        `ADR_CNT0:     dat_d = {24'h000000, cnt0};
        `ADR_CS1:      dat_d = {24'h000000, cs1};
        `ADR_CNT1:     dat_d = {24'h000000, cnt1};
        `ADR_IRQ_STAT: dat_d = {28'h0000000, stat_q};
        `ADR_IRQ_EN:   dat_d = {28'h0000000, ien_q};
        default:       dat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  logic cs_wr0;
  logic cs_wr1;
  logic cnt_wr0;
  logic cnt_wr1;
  logic cs_rd0;
  logic cs_rd1;
  assign cs_wr0  = wr && word_ok && wb_adr_i == `ADR_CS0 && key == `KEY_CTRL;
  assign cnt_wr0 = wr && word_ok && wb_adr_i == `ADR_CS0 && key == `KEY_COUNT;
  assign cs_wr1  = wr && word_ok && wb_adr_i == `ADR_CS1 && key == `KEY_CTRL;
  assign cnt_wr1 = wr && word_ok && wb_adr_i == `ADR_CS1 && key == `KEY_COUNT;
  assign cs_rd0  = commit && !wb_we_i && wb_adr_i == `ADR_CS0;
  assign cs_rd1  = commit && !wb_we_i && wb_adr_i == `ADR_CS1;

  // Three stages; a level counts only once stages two and three agree
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic sub_lvl_q;
  logic sub_lvl_d;
  logic sub_edge;

  always_comb begin
    sub_lvl_d = (sync2_q == sync3_q) ? sync3_q : sub_lvl_q;
  end
  assign sub_edge = sub_lvl_d && !sub_lvl_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      sync3_q   <= 1'b0;
      sub_lvl_q <= 1'b0;
    end else begin
      sync1_q   <= sub_clk_i;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      sub_lvl_q <= sub_lvl_d;
    end
  end

  // Free running, so a divider change mid-count may give one short period
  logic [`MAIN_PRE_W-1:0] pre_q;
  logic [`MAIN_PRE_W-1:0] pre_d;
  logic [`SUB_PRE_W-1:0]  spre_q;
  logic [`SUB_PRE_W-1:0]  spre_d;
  logic [`SUB_PRE_W-1:0]  smask;
  logic [3:0]             sk;
  logic                   tick0;
  logic                   tick1;
  logic                   mtick0;
  logic                   mtick1;
  logic                   stick1;

  always_comb begin
    pre_d  = pre_q + {{(`MAIN_PRE_W-1){1'b0}}, 1'b1};
    spre_d = sub_edge ? spre_q + `CNT_ONE : spre_q;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pre_q  <= {`MAIN_PRE_W{1'b0}};
      spre_q <= `CNT_ZERO;
    end else begin
      pre_q  <= pre_d;
      spre_q <= spre_d;
    end
  end

  assign mtick0 = tap_hit(pre_q, main_mask(cs0[`CS_DIV_HI:`CS_DIV_LO]));
  assign mtick1 = tap_hit(pre_q, main_mask(cs1[`CS_DIV_HI:`CS_DIV_LO]));
  assign sk     = {1'b0, cs1[`CS_DIV_HI:`CS_DIV_LO]} + 4'h1;
  assign smask  = ~(`CNT_MAX << sk);
  assign stick1 = sub_edge && ((spre_q & smask) == smask);
  assign tick0  = mtick0;
  assign tick1  = cs1[`CS_PSS] ? stick1 : mtick1;

  logic ovf_set0;
  logic ovf_set1;
  logic irst_active;
  wdt_channel #(.HAS_PSS (1'b0)) u_ch0 (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .cs_wr_i    (cs_wr0),
    .cnt_wr_i   (cnt_wr0),
    .cs_rd_i    (cs_rd0),
    .wdata_i    (wbyte),
    .tick_i     (tick0),
    .irst_clr_i (irst_active),
    .cs_o       (cs0),
    .count_o    (cnt0),
    .ovf_set_o  (ovf_set0)
  );
  wdt_channel #(.HAS_PSS (1'b1)) u_ch1 (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .cs_wr_i    (cs_wr1),
    .cnt_wr_i   (cnt_wr1),
    .cs_rd_i    (cs_rd1),
    .wdata_i    (wbyte),
    .tick_i     (tick1),
    .irst_clr_i (irst_active),
    .cs_o       (cs1),
    .count_o    (cnt1),
    .ovf_set_o  (ovf_set1)
  );

  assign interval_overflow_irq_o[0] = cs0[`CS_OVF] && !cs0[`CS_MODE];
  assign interval_overflow_irq_o[1] = cs1[`CS_OVF] && !cs1[`CS_MODE];

  logic     rst_req;
  logic     nmi_req;
  logic     nmi_q;
  rst_seq_t seq_q;
  rst_seq_t seq_d;
  logic [9:0] seq_cnt_q;
  logic [9:0] seq_cnt_d;
  assign rst_req = (ovf_set0 && cs0[`CS_MODE] && cs0[`CS_RSEL]) || (ovf_set1 && cs1[`CS_MODE] && cs1[`CS_RSEL]);
  assign nmi_req = (ovf_set0 && cs0[`CS_MODE] && !cs0[`CS_RSEL]) || (ovf_set1 && cs1[`CS_MODE] && !cs1[`CS_RSEL]);

  always_comb begin
    seq_d     = seq_q;
    seq_cnt_d = seq_cnt_q;
    case (seq_q)
      RS_IDLE: begin
        seq_cnt_d = `SEQ_ZERO;
        if (rst_req) begin
          seq_d = RS_BOTH;
        end
      end
      RS_BOTH: begin
        seq_cnt_d = seq_cnt_q + `SEQ_ONE;
        if (seq_cnt_q == `RESET_OUT_N_STATES - `SEQ_ONE) begin
          seq_d = RS_TAIL;
        end
      end
      RS_TAIL: begin
        seq_cnt_d = seq_cnt_q + `SEQ_ONE;
        if (seq_cnt_q == `IRST_CLOCKS - `SEQ_ONE) begin
          seq_d = RS_IDLE;
        end
      end
      default: begin
        seq_d     = RS_IDLE;
        seq_cnt_d = `SEQ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      seq_q     <= RS_IDLE;
      seq_cnt_q <= `SEQ_ZERO;
      nmi_q     <= 1'b0;
    end else begin
      seq_q     <= seq_d;
      seq_cnt_q <= seq_cnt_d;
      nmi_q     <= nmi_req;
    end
  end

  // A further overflow during the sequence does not restart it
  assign irst_active   = seq_q != RS_IDLE;
  assign chip_reset_o  = irst_active;
  assign reset_out_n_o = seq_q != RS_BOTH;
  assign nmi_o         = nmi_q;

  always_comb begin
    stat_d = stat_q;
    ien_d  = ien_q;
    if (wr && wb_adr_i == `ADR_IRQ_CLR) begin
      stat_d = stat_q & ~wb_dat_i[3:0];
    end
    if (wr && wb_adr_i == `ADR_IRQ_EN) begin
      ien_d = wb_dat_i[3:0];
    end
    // New events win over a clear in the same cycle
    stat_d[`IRQ_OVF0] = stat_d[`IRQ_OVF0] || ovf_set0;
    stat_d[`IRQ_OVF1] = stat_d[`IRQ_OVF1] || ovf_set1;
    stat_d[`IRQ_NMI]  = stat_d[`IRQ_NMI] || nmi_req;
    stat_d[`IRQ_IRST] = stat_d[`IRQ_IRST] || (rst_req && !irst_active);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stat_q <= `IRQ_RESET;
      ien_q  <= `IRQ_RESET;
    end else begin
      stat_q <= stat_d;
      ien_q  <= ien_d;
    end
  end

  assign irq_o = |(stat_q & ien_q);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_pin_len;
    !reset_out_n_o |-> seq_cnt_q < `RESET_OUT_N_STATES;
  endproperty
  a_pin_len: assert property (p_pin_len) else $error("reset pin low too long");
  property p_pin_end;
    $rose(reset_out_n_o) |-> $past(seq_cnt_q) == `RESET_OUT_N_STATES - `SEQ_ONE;
  endproperty
  a_pin_end: assert property (p_pin_end) else $error("reset pin pulse wrong length");
  property p_irst_end;
    $fell(chip_reset_o) |-> $past(seq_cnt_q) == `IRST_CLOCKS - `SEQ_ONE;
  endproperty
  a_irst_end: assert property (p_irst_end) else $error("internal reset wrong length");
  property p_rst_start;
    rst_req && !irst_active |=> chip_reset_o && !reset_out_n_o ##1 chip_reset_o && !reset_out_n_o;
  endproperty
  a_rst_start: assert property (p_rst_start) else $error("reset action not started");
  property p_nmi;
    ovf_set0 && cs0[`CS_MODE] && !cs0[`CS_RSEL] |=> nmi_o && reset_out_n_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("NMI action missing");
  property p_interval;
    ovf_set1 && !cs1[`CS_MODE] |=> interval_overflow_irq_o[1] && cs1[`CS_OVF];
  endproperty
  a_interval: assert property (p_interval) else $error("interval request not raised");
  property p_div2;
    cs0[`CS_DIV_HI:`CS_DIV_LO] == 3'd0 && mtick0 |=> !mtick0;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two tap wrong");
endmodule

/* dv/watchdog_ctrl_status_clocksel_bench.sv */
// Self-checking bench for the two-channel watchdog / interval timer
`timescale 1ns/100ps
`include "wdt_defines.svh"
module watchdog_ctrl_status_clocksel_bench;
  typedef struct packed {logic care; logic [31:0] val;} note_t;

  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sub_clk_i = 1'b0;
  logic [2:0]  sub_div = 3'h0;
  logic        chip_reset_o;
  logic        reset_out_n_o;
  logic        nmi_o;
  logic [1:0]  interval_overflow_irq_o;
  logic        irq_o;
  int          fail_count = 0;
  int          checked = 0;
  int          seed = 32'h8187668a;
  int          mdiv[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
  note_t       exp_q[$];
  note_t       note;

  watchdog_ctrl_status_clocksel watchdog_ctrl_status_clocksel_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clk_i(sub_clk_i),
    .chip_reset_o(chip_reset_o), .reset_out_n_o(reset_out_n_o), .nmi_o(nmi_o),
    .interval_overflow_irq_o(interval_overflow_irq_o), .irq_o(irq_o));

  always #25 clock_i = ~clock_i;

  // Sub-clock of exactly ten system clocks keeps tick counts deterministic
  always @(posedge clock_i) begin
    if (sub_div == 3'h4) begin
      sub_div   <= 3'h0;
      sub_clk_i <= ~sub_clk_i;
    end else begin
      sub_div <= sub_div + 3'h1;
    end
  end

  task automatic final_report();
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // Read results are compared here, oldest note first
  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      note = exp_q.pop_front();
      if (note.care) begin
        check("rdata", wb_dat_o, note.val);
      end
    end
  end

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd);
    int n;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, 4'hf, x);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    exp_q.push_back({1'b1, e});
    bus(a, 1'b0, 32'h0, 4'hf, x);
  endtask

  task automatic ctl(input logic [4:0] a, input logic [7:0] v);
    wr(a, {16'h0, `KEY_CTRL, v});
  endtask

  task automatic cnt(input logic [4:0] a, input logic [7:0] v);
    wr(a, {16'h0, `KEY_COUNT, v});
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = interval_overflow_irq_o[0];
      1: sig = nmi_o;
      3: sig = interval_overflow_irq_o[1];
      default: sig = chip_reset_o;
    endcase
  endfunction

  task automatic wait_sig(input int k, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (sig(k) !== 1'b1 && n < lim);
    if (n >= lim) begin
      fail_count++;
      final_report();
    end
  endtask

  // Two counter snapshots exactly win cycles apart differ by win / divisor
  task automatic meas(input logic [4:0] ca, input logic [7:0] v, input int win, input int dlt);
    logic [31:0] x;
    ctl(ca, 8'h00);
    ctl(ca, v);
    exp_q.push_back({1'b0, 32'h0});
    bus(ca + 5'h4, 1'b0, 32'h0, 4'hf, x);
    repeat (win - 3) @(posedge clock_i);
    rd(ca + 5'h4, x + dlt);
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
  endtask

  initial begin
    logic [7:0]  v;
    logic [31:0] x;
    int          n;
    int          low;
    int          w;
    do_reset();
    check("outs", {chip_reset_o, reset_out_n_o, nmi_o, interval_overflow_irq_o, irq_o}, 32'h10);
    rd(`ADR_CS0, 32'h0);
    rd(`ADR_CS1, 32'h0);
    rd(`ADR_CNT0, 32'h0);
    wr(5'h1c, 32'hff);
    rd(5'h1c, 32'h0);
    // Keyed writes; wrong key and byte write leave registers alone
    ctl(`ADR_CS0, 8'h26);
    v = 8'($random(seed));
    cnt(`ADR_CS0, v);
    rd(`ADR_CNT0, {24'h0, v});
    wr(`ADR_CS0, {16'h0, 8'h33, 8'h00});
    rd(`ADR_CS0, 32'h26);
    bus(`ADR_CS0, 1'b1, {16'h0, `KEY_CTRL, 8'h00}, 4'h1, x);
    rd(`ADR_CS0, 32'h26);
    ctl(`ADR_CS0, 8'h10);
    rd(`ADR_CS0, 32'h0);
    cnt(`ADR_CS0, v | 8'h01);
    repeat (20) @(posedge clock_i);
    rd(`ADR_CNT0, 32'h0);
    // Divider taps; ch0 code 7 is left out to keep the run short
    for (int c = 0; c < 7; c++) begin
      w = (mdiv[c] < 4) ? 4 : mdiv[c];
      meas(`ADR_CS0, 8'h20 | 8'(c), w, w / mdiv[c]);
    end
    for (int c = 0; c < 5; c++) begin
      w = (mdiv[c] < 4) ? 4 : mdiv[c];
      meas(`ADR_CS1, 8'h20 | 8'(c), w, w / mdiv[c]);
    end
    for (int c = 0; c < 8; c++) begin
      meas(`ADR_CS1, 8'h30 | 8'(c), ((c == 7) ? 256 : (2 << c)) * 10, 1);
    end
    ctl(`ADR_CS1, 8'h00);
    // Interval overflow, flag clearing protocol and interrupt block
    ctl(`ADR_CS0, 8'h00);
    wr(`ADR_IRQ_EN, 32'h1);
    ctl(`ADR_CS0, 8'h20);
    cnt(`ADR_CS0, 8'hfd);
    wait_sig(0, 100);
    ctl(`ADR_CS0, 8'h20);
    ctl(`ADR_CS0, 8'ha0);
    rd(`ADR_CS0, 32'ha0);
    rd(`ADR_CS0, 32'ha0);
    rd(`ADR_IRQ_STAT, 32'h1);
    check("irq", irq_o, 32'h1);
    check("interval_overflow_irq", interval_overflow_irq_o, 32'h1);
    ctl(`ADR_CS0, 8'h20);
    rd(`ADR_CS0, 32'h20);
    check("interval_overflow_irq", interval_overflow_irq_o, 32'h0);
    ctl(`ADR_CS0, 8'ha0);
    rd(`ADR_CS0, 32'h20);
    wr(`ADR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clock_i);
    check("irq", irq_o, 32'h0);
    wr(`ADR_IRQ_CLR, 32'h1);
    rd(`ADR_IRQ_STAT, 32'h0);
    cnt(`ADR_CS0, 8'hfd);
    wait_sig(0, 100);
    ctl(`ADR_CS0, 8'h00);
    rd(`ADR_CS0, 32'h0);
    rd(`ADR_CNT0, 32'h0);
    // Watchdog with NMI action
    ctl(`ADR_CS0, 8'h60);
    cnt(`ADR_CS0, 8'hfd);
    wait_sig(1, 100);
    check("nmi", {interval_overflow_irq_o, chip_reset_o, reset_out_n_o}, 32'h1);
    @(posedge clock_i);
    check("nmi", nmi_o, 32'h0);
    rd(`ADR_CS0, 32'he0);
    ctl(`ADR_CS0, 8'h00);
    // Interval overflow on channel 1
    ctl(`ADR_CS1, 8'h20);
    cnt(`ADR_CS1, 8'hfd);
    wait_sig(3, 100);
    check("wovi1", interval_overflow_irq_o, 32'h2);
    ctl(`ADR_CS1, 8'h00);
    rd(`ADR_CS1, 32'h0);
    // Watchdog with internal reset action
    ctl(`ADR_CS0, 8'h69);
    cnt(`ADR_CS0, 8'hfd);
    wait_sig(2, 400);
    n = 0;
    low = 0;
    while (chip_reset_o === 1'b1 && n < 600) begin
      n++;
      if (reset_out_n_o === 1'b0) begin
        low++;
      end
      @(posedge clock_i);
    end
    check("rst_len", n, 518);
    check("pin_len", low, 132);
    check("pin", reset_out_n_o, 32'h1);
    rd(`ADR_CS0, 32'h69);
    rd(`ADR_IRQ_STAT, 32'hf);
    ctl(`ADR_CS0, 8'h00);
    // Second reset in mid-run
    ctl(`ADR_CS1, 8'h2b);
    do_reset();
    rd(`ADR_CS1, 32'h0);
    rd(`ADR_IRQ_EN, 32'h0);
    final_report();
  end
endmodule
